//--- core/btg_bus_transaction_generator.sv
// What this block does
// RULE_01: address register loaded by set-address, used by every later operation.
// RULE_02: separate page register; bus address is address OR page.
// RULE_03: size or byte-mask command, only the one matching bus mode loads mask.
// RULE_04: standard mode drives the two size outputs from the 2-bit size.
// RULE_05: enhanced mode drives low address and size pins as active-low byte enables.
// RULE_06: read enqueues at current address; read after read continues as sequential.
// RULE_07: each read compares all 32 bits, masked bits ignored, flags mismatch.
// RULE_08: cache-line read is a read with line-fill output asserted.
// RULE_09: write enqueues data driven at cycle start; write after write is sequential.
// RULE_10: full write is a write with line-fill output asserted.
// RULE_11: idle enqueues count idle cycles, zero ignored, stops merging.
// RULE_12: swap enqueues read then write, lock held across both.
// RULE_13: circular queue, one bus cycle per entry (an idle entry lasts its count), drained in order.
// RULE_14: empty queue leaves the bus idle.
// RULE_15: setting commands only load values; operations write one queue entry, a swap or a direction clash two.
// RULE_16: core-rate or test clock chosen by bypass, divided into memory clock.
// RULE_17: in clock-drive mode output memory clock and complement, odd low longer.
// RULE_18: otherwise memory clock pin released; system supplies the clock.
// RULE_19: wait input sampled each bus cycle stretches it.
// RULE_20: write and read merging sequentially flags error and forces idle cycle.
// RULE_21: system returns read data before dropping wait and accepts write data.
`timescale 1ns/1ns
module btg_bus_transaction_generator #(
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic test_clock_input_in,
  input wire logic clock_bypass_select_in,
  input wire logic [2:0] memory_clock_divisor_field_in,
  input wire logic clock_mode_input_in,
  input wire logic mem_clk_in,
  input wire logic bus_mode_enh_in,
  input wire btg_pkg::btg_cmd_s cmd_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic wait_in,
  input wire logic [31:0] rdata_in,
  output btg_pkg::btg_bus_s bus_out,
  output logic mem_clk_out,
  output logic mem_clk_oe_out,
  output logic memory_bus_clock_inverted_out,
  output logic rd_done_out,
  output logic rd_err_out,
  output logic seq_err_out,
  output logic busy_out
);
  import btg_pkg::*;
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("DEPTH must be a power of two, at least 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage read only by the second
  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic tclk_d_r, mclk_in_d_r;
  wire logic [SYNC_W-1:0] pins = {test_clock_input_in, clock_bypass_select_in,
    memory_clock_divisor_field_in, clock_mode_input_in, mem_clk_in, bus_mode_enh_in,
    wait_in, rdata_in};
  wire logic tclk_s = sync2_r[40];
  wire logic bypass_s = sync2_r[39];
  wire logic [2:0] div_raw_s = sync2_r[38:36];
  wire logic mode_s = sync2_r[35];
  wire logic mclk_in_s = sync2_r[34];
  wire logic enh_s = sync2_r[33];
  wire logic wait_s = sync2_r[32];
  wire logic [31:0] rdata_s = sync2_r[31:0];

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      tclk_d_r <= 1'b0;
      mclk_in_d_r <= 1'b0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      tclk_d_r <= tclk_s;
      mclk_in_d_r <= mclk_in_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock mode strap, caught once the synchronisers hold real pin levels
  logic [1:0] strap_cnt_r;
  logic drive_mode_r;
  logic strap_done_r;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_cnt_r <= '0;
      drive_mode_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == STRAP_WAIT) begin
        drive_mode_r <= mode_s;
        strap_done_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory clock divider; a divisor below two cannot toggle, so it is raised
  logic [2:0] div_cnt_r;
  logic mclk_r, mclk_n_r;
  wire logic [2:0] div = (div_raw_s < DIV_MIN) ? DIV_MIN : div_raw_s;
  wire logic src_tick = bypass_s ? (tclk_s & ~tclk_d_r) : 1'b1; // [RULE_16]
  wire logic cnt_wrap = div_cnt_r >= div - 3'h1;
  wire logic [2:0] cnt_nxt = !src_tick ? div_cnt_r : (cnt_wrap ? 3'h0 : div_cnt_r + 3'h1);
  wire logic mclk_nxt = cnt_nxt < (div >> 1); // [RULE_17]
  wire logic own_rise = drive_mode_r && src_tick && cnt_nxt == 3'h0;
  wire logic ext_rise = !drive_mode_r && mclk_in_s && !mclk_in_d_r; // [RULE_18]
  wire logic tick = strap_done_r && (own_rise || ext_rise);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_r <= 3'h0;
      mclk_r <= 1'b0;
      mclk_n_r <= 1'b0;
    end else begin
      div_cnt_r <= cnt_nxt;
      mclk_r <= drive_mode_r & mclk_nxt;
      mclk_n_r <= drive_mode_r & ~mclk_nxt; // [RULE_17]
    end
  end
  assign mem_clk_out = mclk_r;
  assign memory_bus_clock_inverted_out = mclk_n_r;
  assign mem_clk_oe_out = drive_mode_r; // [RULE_18]

  ////////////////////////////////////////////////////////////////////////////
  // setting registers and enqueue decode
  logic [31:0] addr_r, page_r;
  logic [3:0] mask_r;
  btg_op_e last_r;
  btg_ent_s q_mem [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] count_r;
  logic ready_r, seq_err_r;
  btg_ent_s cur_r;
  logic busy_r;
  logic [IDLE_W-1:0] idle_left_r;

  wire logic accept = cmd_valid_in && ready_r;
  wire logic is_rd = cmd_in.op == CMD_RD || cmd_in.op == CMD_CRD;
  wire logic is_wr = cmd_in.op == CMD_WR || cmd_in.op == CMD_FWR;
  wire logic is_sw = cmd_in.op == CMD_SWAP;
  wire logic is_idle = cmd_in.op == CMD_IDLE && cmd_in.data[IDLE_W-1:0] != '0; // [RULE_11]
  wire logic live = count_r != '0 || busy_r;
  wire logic clash = live && ((is_rd && last_r == OP_WRITE) ||
    (is_wr && last_r == OP_READ)); // [RULE_20]
  wire logic same_dir = live && ((is_rd && last_r == OP_READ) ||
    (is_wr && last_r == OP_WRITE));
  wire btg_ent_s main_ent = '{op: is_idle ? OP_IDLE : (is_wr ? OP_WRITE : OP_READ),
    seq: same_dir, // [RULE_06] [RULE_09]
    clf: cmd_in.op == CMD_CRD || cmd_in.op == CMD_FWR, // [RULE_08] [RULE_10]
    lock: is_sw, mask: mask_r, addr: addr_r | page_r, // [RULE_01] [RULE_02]
    data: cmd_in.data, care: is_wr ? 32'hFFFF_FFFF : cmd_in.care,
    idle_n: cmd_in.data[IDLE_W-1:0]};
  wire btg_ent_s gap_ent = '{op: OP_IDLE, seq: 1'b0, clf: 1'b0, lock: 1'b0, mask: mask_r,
    addr: addr_r | page_r, data: 32'h0000_0000, care: 32'h0000_0000,
    idle_n: IDLE_W'(1)};
  wire btg_ent_s swap_wr = '{op: OP_WRITE, seq: 1'b0, clf: 1'b0, lock: 1'b1, mask: mask_r,
    addr: addr_r | page_r, data: cmd_in.data2, care: 32'hFFFF_FFFF,
    idle_n: '0}; // [RULE_12]
  wire logic [1:0] n_push = !accept ? 2'h0 :
    (is_sw || clash) ? 2'h2 : (is_rd || is_wr || is_idle) ? 2'h1 : 2'h0; // [RULE_15]
  wire btg_ent_s slot0 = clash ? gap_ent : main_ent;
  wire btg_ent_s slot1 = clash ? main_ent : swap_wr;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_r <= RST_ADDR;
      page_r <= RST_PAGE;
      mask_r <= RST_MASK;
      last_r <= OP_IDLE;
      seq_err_r <= 1'b0;
    end else begin
      seq_err_r <= accept && clash; // [RULE_20]
      if (accept) begin
        unique case (cmd_in.op)
          CMD_SET_ADDR: addr_r <= cmd_in.data; // [RULE_01]
          CMD_SET_PAGE: page_r <= cmd_in.data; // [RULE_02]
          CMD_SET_SIZE: if (!enh_s) mask_r <= {2'h0, cmd_in.data[1:0]}; // [RULE_03]
          CMD_SET_BYTES: if (enh_s) mask_r <= cmd_in.data[3:0]; // [RULE_03]
          CMD_RD, CMD_CRD: last_r <= OP_READ;
          CMD_WR, CMD_FWR, CMD_SWAP: last_r <= OP_WRITE;
          CMD_IDLE: if (is_idle) last_r <= OP_IDLE;
          default: last_r <= last_r;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // circular queue, one entry per bus cycle, an idle entry held for its count
  wire logic stall = busy_r && cur_r.op != OP_IDLE && wait_s; // [RULE_19]
  wire logic advance = tick && !stall;
  wire logic idle_more = busy_r && cur_r.op == OP_IDLE && idle_left_r > IDLE_W'(1);
  wire logic pop = advance && !idle_more && count_r != '0; // [RULE_13]
  wire btg_ent_s head = q_mem[rp_r];
  wire logic beat_done = advance && busy_r && cur_r.op != OP_IDLE;
  wire logic mism = |((rdata_s ^ cur_r.data) & cur_r.care); // [RULE_07]
  wire logic [AW:0] count_nxt = count_r + (AW+1)'(n_push) - (AW+1)'(pop);

  always_ff @(posedge core_clk_in) begin
    if (n_push != 2'h0) q_mem[wp_r] <= slot0;
    if (n_push == 2'h2) q_mem[wp_r + AW'(1)] <= slot1;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_r <= '0;
      rp_r <= '0;
      count_r <= '0;
      ready_r <= 1'b0;
    end else begin
      wp_r <= wp_r + AW'(n_push);
      rp_r <= rp_r + AW'(pop);
      count_r <= count_nxt;
      ready_r <= count_nxt <= (AW+1)'(DEPTH - 2);
    end
  end
  assign cmd_ready_out = ready_r;

  ////////////////////////////////////////////////////////////////////////////
  // bus engine, steps on each memory clock rise not held by wait
  wire btg_ent_s cur_nxt = pop ? head : cur_r;
  wire logic busy_nxt = pop || idle_more;
  wire logic beat_nxt = busy_nxt && cur_nxt.op != OP_IDLE; // [RULE_14]
  wire btg_bus_s bus_nxt = '{
    addr: enh_s ? {cur_nxt.addr[31:2], cur_nxt.mask[1:0]} : cur_nxt.addr, // [RULE_05]
    size: enh_s ? cur_nxt.mask[3:2] : cur_nxt.mask[1:0], // [RULE_04] [RULE_05]
    req: beat_nxt, seq: beat_nxt && cur_nxt.seq,
    wr: beat_nxt && cur_nxt.op == OP_WRITE,
    clf: beat_nxt && cur_nxt.clf, lock: beat_nxt && cur_nxt.lock, // [RULE_12]
    wdata: cur_nxt.data, // [RULE_09]
    data_oe: beat_nxt && cur_nxt.op == OP_WRITE};
  btg_bus_s bus_r;
  logic rd_done_r, rd_err_r;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur_r <= '0;
      busy_r <= 1'b0;
      idle_left_r <= '0;
      bus_r <= '0;
      rd_done_r <= 1'b0;
      rd_err_r <= 1'b0;
    end else begin
      rd_done_r <= beat_done && cur_r.op == OP_READ;
      rd_err_r <= beat_done && cur_r.op == OP_READ && mism; // [RULE_07]
      if (advance) begin
        cur_r <= cur_nxt;
        busy_r <= busy_nxt;
        idle_left_r <= pop ? head.idle_n : idle_left_r - IDLE_W'(idle_more);
        bus_r <= bus_nxt;
      end
    end
  end
  assign bus_out = bus_r;
  assign rd_done_out = rd_done_r;
  assign rd_err_out = rd_err_r;
  assign seq_err_out = seq_err_r;
  assign busy_out = busy_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence beat_end_s;
    beat_done && cur_r.op == OP_READ;
  endsequence
  sequence held_s;
    tick && stall;
  endsequence

  addr_page_or_a: assert property (accept && is_rd && !clash |=> // [RULE_02]
    q_mem[$past(wp_r)].addr == ($past(addr_r) | $past(page_r)))
    else $error("queued address is not address OR page");
  size_mask_a: assert property (accept && cmd_in.op == CMD_SET_SIZE && enh_s // [RULE_03]
    |=> mask_r == $past(mask_r)) else $error("size command changed mask in enhanced mode");
  read_check_a: assert property (beat_end_s |=> rd_done_r && rd_err_r == $past(mism)) // [RULE_07]
    else $error("read compare result wrong");
  wait_stretch_a: assert property (held_s |=> $stable(bus_r) && busy_r) // [RULE_19]
    else $error("bus moved while wait asserted");
  idle_bus_a: assert property (!busy_r |-> !bus_r.req && !bus_r.data_oe) // [RULE_14]
    else $error("bus active with nothing queued");
  zero_idle_a: assert property (accept && cmd_in.op == CMD_IDLE && // [RULE_11]
    cmd_in.data[IDLE_W-1:0] == '0 |=> count_r == $past(count_r) - (AW+1)'($past(pop)))
    else $error("zero idle count was queued");
  swap_lock_a: assert property (accept && is_sw |=> count_r == $past(count_r) + // [RULE_12]
    (AW+1)'(2) - (AW+1)'($past(pop)) && q_mem[$past(wp_r)].lock &&
    q_mem[$past(wp_r) + AW'(1)].op == OP_WRITE) else $error("swap not queued locked");
  setting_a: assert property (accept && cmd_in.op inside {CMD_SET_ADDR, CMD_SET_PAGE} // [RULE_15]
    |=> count_r == $past(count_r) - (AW+1)'($past(pop))) else $error("setting queued work");
  clash_gap_a: assert property (accept && clash |=> seq_err_r && // [RULE_20]
    q_mem[$past(wp_r)].op == OP_IDLE) else $error("no gap forced after direction clash");
  clk_release_a: assert property (strap_done_r && !drive_mode_r |-> // [RULE_18]
    !mem_clk_oe_out && !mem_clk_out) else $error("memory clock driven in input mode");
endmodule

//--- core/btg_pkg.sv
package btg_pkg;
  typedef enum logic [3:0] {
    CMD_SET_ADDR, CMD_SET_PAGE, CMD_SET_SIZE, CMD_SET_BYTES, CMD_RD,
    CMD_CRD, CMD_WR, CMD_FWR, CMD_IDLE, CMD_SWAP
  } btg_cmd_e;
  typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} btg_op_e;
  localparam int IDLE_W = 8;
  typedef struct packed {
    btg_cmd_e op;
    logic [31:0] data;
    logic [31:0] data2;
    logic [31:0] care;
  } btg_cmd_s;
  typedef struct packed {
    btg_op_e op;
    logic seq;
    logic clf;
    logic lock;
    logic [3:0] mask;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] care;
    logic [IDLE_W-1:0] idle_n;
  } btg_ent_s;
  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic req;
    logic seq;
    logic wr;
    logic clf;
    logic lock;
    logic [31:0] wdata;
    logic data_oe;
  } btg_bus_s;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_PAGE = 32'h0000_0000;
  localparam logic [3:0] RST_MASK = 4'h2;
  localparam logic [2:0] DIV_MIN = 3'h2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam int SYNC_W = 41;
endpackage

//--- test/btg_mem_model.sv
`timescale 1ns/1ns
module btg_mem_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire btg_pkg::btg_bus_s bus_in,
  input wire logic slow_in,
  output logic wait_out,
  output logic [31:0] rdata_out
);
  import btg_pkg::*;
  logic [31:0] mem_r [64];
  logic [31:0] last_r;
  logic [7:0] age_r;
  btg_bus_s prev_r;
  wire logic fresh = bus_in !== prev_r;
  wire logic rd_beat = bus_in.req && !bus_in.wr;
  // wait stays up until the word has stood well past the two-flop sampler
  assign wait_out = fresh || age_r < (slow_in ? 8'h28 : 8'h04);
  // released lines show the inverse of the previous cycle's value, so they toggle back to the last word every other cycle
  assign rdata_out = rd_beat ? mem_r[bus_in.addr[7:2]] : ~last_r;
  initial for (int i = 0; i < 64; i++) mem_r[i] = 32'hC0DE_0000 | i;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r <= '0;
      age_r <= 8'h00;
      last_r <= 32'h0000_0000;
    end else begin
      prev_r <= bus_in;
      age_r <= fresh ? 8'h00 : (age_r == 8'hFF ? age_r : age_r + 8'h01);
      last_r <= rdata_out;
      if (bus_in.req && bus_in.wr && bus_in.data_oe) mem_r[bus_in.addr[7:2]] <= bus_in.wdata;
    end
  end
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import btg_pkg::*;
  logic clk = 0, rst_n = 0, tck = 0, byp = 1, smode = 1, mclk = 0, enh = 0, vld = 0, slow = 0;
  logic [2:0] div = 3'h2;
  btg_cmd_s cmd = '0;
  btg_bus_s bus, prev, beats[$];
  logic rdy, wt, oe, mck, nmck, done, err, serr, busy;
  logic [31:0] rdata;
  int num_errors = 0, tests_run = 0, n_done = 0, n_err = 0, n_serr = 0;
  int mdiv = 0;
  initial forever #25 clk = ~clk;
  // unrelated test clock, free running at an eighth of the core rate
  initial forever #200 tck = ~tck;
  btg_bus_transaction_generator dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .test_clock_input_in(tck), .clock_bypass_select_in(byp),
    .memory_clock_divisor_field_in(div), .clock_mode_input_in(smode), .mem_clk_in(mclk),
    .bus_mode_enh_in(enh), .cmd_in(cmd), .cmd_valid_in(vld), .cmd_ready_out(rdy),
    .wait_in(wt), .rdata_in(rdata), .bus_out(bus), .mem_clk_out(mck), .mem_clk_oe_out(oe),
    .memory_bus_clock_inverted_out(nmck), .rd_done_out(done), .rd_err_out(err),
    .seq_err_out(serr), .busy_out(busy));
  btg_mem_model mem (.clk_in(clk), .rst_n_in(rst_n), .bus_in(bus), .slow_in(slow),
    .wait_out(wt), .rdata_out(rdata));
  // far side supplies the memory clock once the block has released it
  always @(posedge clk) begin
    mdiv <= (mdiv == 3) ? 0 : mdiv + 1;
    if (!smode && mdiv == 3) mclk <= ~mclk;
  end
  always @(posedge clk) begin
    n_done += (done === 1'b1);
    n_err += (err === 1'b1);
    n_serr += (serr === 1'b1);
    if (bus !== prev) beats.push_back(bus);
    prev = bus;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // flags are {req, wr, seq, clf, lock}
  task automatic beat(input int i, input logic [4:0] f, input logic [31:0] a);
    btg_bus_s b;
    b = i < beats.size() ? beats[i] : '0;
    chk({b.req, b.wr, b.seq, b.clf, b.lock}, f, "flags");
    chk(b.addr, a, "addr");
  endtask
  // valid stays high between back-to-back commands; drain drops it
  task automatic send(input btg_cmd_e op, input logic [31:0] d, input logic [31:0] d2 = '0,
                      input logic [31:0] c = '1);
    int n;
    n = 0;
    cmd <= '{op, d, d2, c};
    vld <= 1'b1;
    // held until an edge at which ready was high, so nothing is dropped
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    if (rdy !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic drain;
    int q, n;
    q = 0;
    n = 0;
    vld <= 1'b0;
    while (q < 40 && n < 4000) begin
      @(posedge clk);
      n++;
      q = (busy === 1'b0) ? q + 1 : 0;
    end
    if (n == 4000) begin
      num_errors++;
      conclude();
    end
    beats = {};
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_rw;
    int d0;
    d0 = n_done;
    send(CMD_SET_ADDR, 32'h0000_0010);
    send(CMD_SET_PAGE, 32'h4000_0000);
    send(CMD_WR, 32'h1234_5678);
    send(CMD_SET_ADDR, 32'h0000_0014);
    send(CMD_WR, 32'hAAAA_5555);
    send(CMD_IDLE, 32'h0000_0001);
    send(CMD_SET_ADDR, 32'h0000_0010);
    send(CMD_RD, 32'h1234_5678);
    send(CMD_IDLE, 32'h0000_0000);
    send(CMD_SET_ADDR, 32'h0000_0014);
    send(CMD_RD, 32'hAAAA_5555);
    vld <= 1'b0;
    repeat (200) @(posedge clk);
    beat(0, 5'b11000, 32'h4000_0010);
    chk(beats[0].wdata, 32'h1234_5678, "wdata");
    chk(beats[0].size, 2'h2, "size");
    chk({beats[0].data_oe, beats[3].data_oe}, 2'h2, "data drive");
    beat(1, 5'b11100, 32'h4000_0014);
    chk(beats[2].req, 1'b0, "idle");
    beat(3, 5'b10000, 32'h4000_0010);
    beat(4, 5'b10100, 32'h4000_0014);
    chk(beats[5].req, 1'b0, "empty");
    chk(n_done - d0, 2, "reads");
    drain();
  endtask
  task automatic s_cmp;
    int e0, d0, t;
    e0 = n_err;
    d0 = n_done;
    t = 0;
    slow <= 1'b1;
    send(CMD_SET_ADDR, 32'h0000_0018);
    send(CMD_RD, 32'hC0DE_0007);
    send(CMD_IDLE, 32'h0000_0001);
    send(CMD_SET_ADDR, 32'h0000_001C);
    send(CMD_RD, 32'h00DE_0007, 32'h0, 32'h00FF_FFFF);
    vld <= 1'b0;
    while (n_done == d0 && t < 500) begin
      @(posedge clk);
      t++;
    end
    chk(t > 30 && t < 500, 1'b1, "stretch");
    drain();
    slow <= 1'b0;
    chk(n_done - d0, 2, "reads");
    chk(n_err - e0, 1, "mismatch");
  endtask
  task automatic s_clf_swap;
    int e0;
    e0 = n_err;
    send(CMD_SET_ADDR, 32'h0000_0020);
    send(CMD_CRD, 32'hC0DE_0008);
    send(CMD_IDLE, 32'h0000_0001);
    send(CMD_FWR, 32'h5A5A_0000);
    send(CMD_IDLE, 32'h0000_0001);
    send(CMD_SWAP, 32'h5A5A_0000, 32'h0F0F_F0F0);
    vld <= 1'b0;
    repeat (200) @(posedge clk);
    beat(0, 5'b10010, 32'h4000_0020);
    beat(2, 5'b11010, 32'h4000_0020);
    beat(4, 5'b10001, 32'h4000_0020);
    beat(5, 5'b11001, 32'h4000_0020);
    chk(beats[5].wdata, 32'h0F0F_F0F0, "swap data");
    chk({beats[6].req, beats[6].lock}, 2'h0, "unlock");
    chk(n_err - e0, 0, "clean");
    drain();
  endtask
  task automatic s_seqerr;
    int s0;
    s0 = n_serr;
    send(CMD_WR, 32'h0000_0001);
    send(CMD_RD, 32'h0000_0001);
    vld <= 1'b0;
    repeat (120) @(posedge clk);
    chk(n_serr - s0, 1, "clash");
    beat(0, 5'b11000, 32'h4000_0020);
    chk(beats[1].req, 1'b0, "forced idle");
    beat(2, 5'b10000, 32'h4000_0020);
    drain();
  endtask
  task automatic s_modes;
    int e0;
    e0 = n_err;
    send(CMD_SET_SIZE, 32'h0000_0001);
    send(CMD_SET_BYTES, 32'h0000_0003);
    send(CMD_RD, 32'h0000_0001);
    vld <= 1'b0;
    repeat (60) @(posedge clk);
    chk(beats[0].size, 2'h1, "std size");
    drain();
    enh <= 1'b1;
    drain();
    send(CMD_SET_BYTES, 32'h0000_000C);
    send(CMD_SET_SIZE, 32'h0000_0001);
    send(CMD_RD, 32'h0000_0001);
    vld <= 1'b0;
    repeat (60) @(posedge clk);
    chk({beats[0].size, beats[0].addr[1:0]}, 4'hC, "enables");
    chk(n_err - e0, 0, "clean");
    drain();
  endtask
  task automatic s_clock;
    int h, m, d0, e0;
    h = 0;
    m = 0;
    byp <= 1'b0;
    div <= 3'h3;
    repeat (20) @(posedge clk);
    repeat (12) begin
      @(posedge clk);
      h += (mck === 1'b1);
      m += (nmck !== ~mck || oe !== 1'b1);
    end
    chk(h, 4, "high share");
    chk(m, 0, "complement");
    rst_n <= 1'b0;
    smode <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    chk({oe, mck, nmck}, 3'h0, "released");
    d0 = n_done;
    e0 = n_err;
    send(CMD_RD, 32'hC0DE_0000);
    vld <= 1'b0;
    repeat (60) @(posedge clk);
    chk(n_done - d0, 1, "ext clock read");
    chk(n_err - e0, 0, "ext clock data");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    chk({rdy, busy, bus.req}, 3'h0, "reset idle");
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(rdy, 1'b1, "ready");
    // the bus settling out of reset is not a beat
    beats = {};
    s_rw();
    s_cmp();
    s_clf_swap();
    s_seqerr();
    s_modes();
    s_clock();
    conclude();
  end
endmodule
